// ### design/feat_id_pkg.sv
// Package for the feature identification register group.
// Assumes one core clock; requests come from logic on that clock.

package feat_id_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int unsigned ADDR_W            = 12;
	localparam logic [11:0] OFF_IMPL_IDENTITY = 12'h018;
	localparam logic [11:0] OFF_IMPL_FEATURES = 12'h028;
	localparam logic [11:0] OFF_BW_FEATURES   = 12'h040;
	localparam logic [11:0] OFF_MON_FEATURES  = 12'h090;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned ID_PART_LSB     = 20;
	localparam int unsigned ID_MAJOR_LSB    = 16;
	localparam int unsigned ID_MINOR_LSB    = 12;
	localparam int unsigned ID_BANK_LSB     = 8;
	localparam int unsigned ID_ZERO_BIT     = 7;
	localparam int unsigned BW_PBM_LSB      = 16;
	localparam int unsigned BW_WINWR_BIT    = 14;
	localparam int unsigned BW_STRIDE_BIT   = 13;
	localparam int unsigned BW_PBM_BIT      = 12;
	localparam int unsigned BW_CEIL_BIT     = 11;
	localparam int unsigned BW_FLOOR_BIT    = 10;
	localparam int unsigned MON_CAPTURE_BIT = 31;
	localparam int unsigned MAIN_BW_BIT     = 26;
	localparam int unsigned MAIN_MON_BIT    = 30;
	localparam int unsigned MONF_BWU_BIT    = 17;

	// ----------------------------------------
	// Field limits and reset values
	// ----------------------------------------
	localparam logic [12:0] BW_PBM_MAX    = 13'h1000;
	localparam logic [5:0]  BW_ALLOC_MAX  = 6'h10;
	localparam logic [31:0] RSP_DATA_RST  = 32'h0000_0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic              valid;
		logic              write;
		logic              secure;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [31:0] rdata;
	} rsp_t;

endpackage : feat_id_pkg

// ### design/feat_id_regs.sv
// Read-only feature identification registers of the feature frame.
// Assumes a requester on CORE_CLK_I that issues at most one access per
// cycle and takes the answer one cycle later.

`timescale 1ns/1ps
`default_nettype none

module feat_id_regs #(
	parameter logic [11:0] PART_IDENT      = 12'h001, // Arbitrary value
	parameter logic [3:0]  MAJOR_REV       = 4'h0,
	parameter logic [3:0]  MINOR_REV       = 4'h0,
	parameter logic [3:0]  MAKER_BANK      = 4'h0,    // Arbitrary value
	parameter logic [6:0]  MAKER_CODE      = 7'h01,   // Arbitrary value
	parameter logic [31:0] IMPL_FEAT_NS    = 32'h0000_0000,
	parameter logic [31:0] IMPL_FEAT_S     = 32'h0000_0000,
	parameter logic [31:0] MAIN_FEATURES   = 32'h4400_0000,
	parameter logic [31:0] MON_FEATURES    = 32'h0002_0000,
	parameter logic [12:0] PBM_WIDTH       = 13'h0020,
	parameter logic        WIN_WRITABLE    = 1'b1,
	parameter logic        HAS_STRIDE      = 1'b1,
	parameter logic        PORTION_BITMAP_PRESENT         = 1'b1,
	parameter logic        HAS_CEIL        = 1'b1,
	parameter logic        HAS_FLOOR       = 1'b1,
	parameter logic [5:0]  ALLOC_WIDTH     = 6'h08,
	parameter logic        HAS_CAPTURE     = 1'b1,
	parameter logic [15:0] MON_COUNT_NS    = 16'h0004,
	parameter logic [15:0] MON_COUNT_S     = 16'h0004
) (
	input  wire logic               CORE_CLK_I,
	input  wire logic               NRST_I,
	input  wire feat_id_pkg::req_t  REQ_I,
	output var  feat_id_pkg::rsp_t  RSP_O
);
	import feat_id_pkg::*;

	// ----------------------------------------
	// Fixed register images
	// ----------------------------------------
	// Identity ignores the security state: one copy serves both maps
	localparam logic [31:0] ID_WORD = {PART_IDENT, MAJOR_REV, MINOR_REV,
		MAKER_BANK, 1'b0, MAKER_CODE};

	localparam logic BW_PRESENT  = MAIN_FEATURES[MAIN_BW_BIT];
	localparam logic MON_PRESENT = MAIN_FEATURES[MAIN_MON_BIT]
		& MON_FEATURES[MONF_BWU_BIT];

	localparam logic [31:0] BW_WORD = {3'h0, PBM_WIDTH, 1'b0, WIN_WRITABLE,
		HAS_STRIDE, PORTION_BITMAP_PRESENT, HAS_CEIL, HAS_FLOOR, 4'h0,
		ALLOC_WIDTH};

	// Only the monitor and implementation words may differ by map
	localparam logic [31:0] MON_WORD_NS = {HAS_CAPTURE, 15'h0000,
		MON_COUNT_NS};
	localparam logic [31:0] MON_WORD_S  = {HAS_CAPTURE, 15'h0000,
		MON_COUNT_S};

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Picks the copy of a banked word that the requesting map sees
	function automatic logic [31:0] bank_sel(input logic secure,
		input logic [31:0] s_word, input logic [31:0] ns_word);
		return secure ? s_word : ns_word;
	endfunction : bank_sel

	// Returns {hit, data}; the secure bit only picks between banked copies,
	// so the full frame answers in both maps
	function automatic logic [32:0] decode(input logic [ADDR_W-1:0] addr,
		input logic secure);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		unique case (addr)
			OFF_IMPL_IDENTITY: r = {1'b1, ID_WORD};
			OFF_IMPL_FEATURES: r = {1'b1, bank_sel(secure, IMPL_FEAT_S,
				IMPL_FEAT_NS)};
			OFF_BW_FEATURES: begin
				// Absent register reads zero and flags an error
				if (BW_PRESENT) begin
					r = {1'b1, BW_WORD};
				end
			end
			OFF_MON_FEATURES: begin
				if (MON_PRESENT) begin
					r = {1'b1, bank_sel(secure, MON_WORD_S,
						MON_WORD_NS)};
				end
			end
			default: r = {1'b0, 32'h0000_0000};
		endcase
		return r;
	endfunction : decode

	// ----------------------------------------
	// Response path
	// ----------------------------------------
	rsp_t        rsp_d;
	rsp_t        rsp_q;
	logic [32:0] hit_data;

	always_comb begin
		hit_data    = decode(REQ_I.addr, REQ_I.secure);
		rsp_d       = '0;
		rsp_d.valid = REQ_I.valid;
		if (REQ_I.valid) begin
			if (REQ_I.write) begin
				// Writes are dropped: nothing here can change
				rsp_d.err   = 1'b1;
				rsp_d.rdata = RSP_DATA_RST;
			end else begin
				rsp_d.err   = ~hit_data[32];
				rsp_d.rdata = hit_data[31:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	assign RSP_O = rsp_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!NRST_I);

	logic rd_req;
	assign rd_req = REQ_I.valid & ~REQ_I.write;

	a_rsp_one_cycle: assert property (
		REQ_I.valid |=> RSP_O.valid ##1 (RSP_O.valid == $past(REQ_I.valid)))
		else $error("answer not one cycle after request");

	a_ident_shared: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_IDENTITY
		|=> !RSP_O.err && RSP_O.rdata == ID_WORD)
		else $error("identity word wrong or differs by map");

	a_ident_fields: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_IDENTITY
		|=> RSP_O.rdata[ID_ZERO_BIT] == 1'b0
		&& RSP_O.rdata[31:ID_PART_LSB] == PART_IDENT
		&& RSP_O.rdata[ID_BANK_LSB +: 4] == MAKER_BANK)
		else $error("identity fields misplaced");

	a_impl_banked: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_FEATURES
		|=> RSP_O.rdata == ($past(REQ_I.secure) ? IMPL_FEAT_S : IMPL_FEAT_NS))
		else $error("implementation word wrong copy");

	a_bw_gated: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES
		|=> RSP_O.err == !BW_PRESENT
		&& RSP_O.rdata == (BW_PRESENT ? BW_WORD : 32'h0000_0000))
		else $error("bandwidth register gating wrong");

	a_bw_ranges: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[28:16] != 13'h0000 && RSP_O.rdata[28:16] <= BW_PBM_MAX
		&& RSP_O.rdata[5:0] != 6'h00 && RSP_O.rdata[5:0] <= BW_ALLOC_MAX
		&& RSP_O.rdata[31:29] == 3'h0 && RSP_O.rdata[9:6] == 4'h0)
		else $error("bandwidth field out of range");

	a_mon_word: assert property (
		rd_req && REQ_I.addr == OFF_MON_FEATURES
		|=> RSP_O.err == !MON_PRESENT
		&& RSP_O.rdata[30:16] == 15'h0000
		&& RSP_O.rdata[15:0] == (MON_PRESENT ? ($past(REQ_I.secure)
			? MON_COUNT_S : MON_COUNT_NS) : 16'h0000))
		else $error("monitor register wrong");

	a_write_ignored: assert property (
		REQ_I.valid && REQ_I.write
		|=> RSP_O.err && RSP_O.rdata == 32'h0000_0000)
		else $error("write not refused");

	a_unmapped_err: assert property (
		rd_req && REQ_I.addr != OFF_IMPL_IDENTITY
		&& REQ_I.addr != OFF_IMPL_FEATURES && REQ_I.addr != OFF_BW_FEATURES
		&& REQ_I.addr != OFF_MON_FEATURES
		|=> RSP_O.err && RSP_O.rdata == 32'h0000_0000)
		else $error("unmapped read not flagged");

	a_first_quiet: assert property (
		$rose(NRST_I)
		|-> RSP_O == '0)
		else $error("answer right after reset release");

	a_frame_ns_map: assert property (
		rd_req && !REQ_I.secure && REQ_I.addr == OFF_IMPL_FEATURES
		|=> RSP_O.valid
		&& !RSP_O.err)
		else $error("frame not decoded in non-secure map");

	a_ident_revs: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_IDENTITY
		|=> RSP_O.rdata[ID_MAJOR_LSB +: 4] == MAJOR_REV
		&& RSP_O.rdata[ID_MINOR_LSB +: 4] == MINOR_REV)
		else $error("identity revision fields misplaced");

	a_maker_code: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_IDENTITY
		|=> RSP_O.rdata[ID_ZERO_BIT-1:0] == MAKER_CODE)
		else $error("maker code misplaced");

	a_ident_both_maps: assert property (
		rd_req && REQ_I.secure && REQ_I.addr == OFF_IMPL_IDENTITY
		|=> !RSP_O.err
		&& RSP_O.rdata[ID_PART_LSB +: 12] == PART_IDENT)
		else $error("identity differs in secure map");

	a_impl_word: assert property (
		rd_req && REQ_I.addr == OFF_IMPL_FEATURES
		|=> RSP_O.valid
		&& !RSP_O.err)
		else $error("implementation word not answered");

	a_bw_bitmap: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[BW_PBM_LSB +: 13] == PBM_WIDTH)
		else $error("bitmap width misplaced");

	a_bw_window: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[BW_WINWR_BIT] == WIN_WRITABLE)
		else $error("window flag misplaced");

	a_bw_schemes: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[BW_STRIDE_BIT] == HAS_STRIDE
		&& RSP_O.rdata[BW_PBM_BIT] == PORTION_BITMAP_PRESENT)
		else $error("stride or bitmap flag misplaced");

	a_bw_limits: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[BW_CEIL_BIT] == HAS_CEIL
		&& RSP_O.rdata[BW_FLOOR_BIT] == HAS_FLOOR)
		else $error("ceiling or floor flag misplaced");

	a_bw_alloc: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES && BW_PRESENT
		|=> RSP_O.rdata[5:0] == ALLOC_WIDTH)
		else $error("allocation width misplaced");

	a_bw_reserved: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES
		|=> RSP_O.rdata[BW_WINWR_BIT+1] == 1'b0
		&& RSP_O.rdata[9:6] == 4'h0)
		else $error("bandwidth reserved bits set");

	a_bw_presence: assert property (
		rd_req && REQ_I.addr == OFF_BW_FEATURES
		|=> RSP_O.err == !MAIN_FEATURES[MAIN_BW_BIT])
		else $error("bandwidth presence flag ignored");

	a_mon_capture: assert property (
		rd_req && REQ_I.addr == OFF_MON_FEATURES && MON_PRESENT
		|=> RSP_O.rdata[MON_CAPTURE_BIT] == HAS_CAPTURE)
		else $error("capture flag misplaced");

	a_mon_count: assert property (
		rd_req && REQ_I.addr == OFF_MON_FEATURES && MON_PRESENT
		|=> RSP_O.rdata[15:0] == ($past(REQ_I.secure) ? MON_COUNT_S : MON_COUNT_NS))
		else $error("monitor count wrong");

	a_mon_presence: assert property (
		rd_req && REQ_I.addr == OFF_MON_FEATURES
		|=> RSP_O.err == !(MAIN_FEATURES[MAIN_MON_BIT]
		&& MON_FEATURES[MONF_BWU_BIT]))
		else $error("monitor presence flags ignored");

	a_idle_quiet: assert property (
		!REQ_I.valid
		|=> RSP_O == '0)
		else $error("answer without request");

	a_answer_cause: assert property (
		RSP_O.valid
		|-> $past(REQ_I.valid))
		else $error("answer with no request before it");

	a_err_no_data: assert property (
		RSP_O.err
		|-> RSP_O.valid && RSP_O.rdata == 32'h0000_0000)
		else $error("error answer carries data");

	c_secure_ident: cover property (
		rd_req && REQ_I.secure && REQ_I.addr == OFF_IMPL_IDENTITY);
	c_ns_bw: cover property (
		rd_req && !REQ_I.secure && REQ_I.addr == OFF_BW_FEATURES);
	c_mon_read: cover property (rd_req && REQ_I.addr == OFF_MON_FEATURES);
	c_write: cover property (REQ_I.valid && REQ_I.write);
	c_back_to_back: cover property (rd_req ##1 rd_req);

endmodule : feat_id_regs

`default_nettype wire

// ### verification/tb_feat_id_regs.sv
// Testbench for the feature identification registers.
// Assumes feat_id_pkg is compiled first; the bench drives REQ_I itself.
`timescale 1ns/1ps
`default_nettype none
module tb_feat_id_regs;
	import feat_id_pkg::*;
	// ----------------------------------------
	// Setup
	// ----------------------------------------
	localparam logic [31:0] ID_EXP = {12'h5a5, 4'h0, 4'h0, 4'h0, 1'b0, 7'h01};
	localparam logic [31:0] ID_B   = {12'h001, 4'h0, 4'h0, 4'h0, 1'b0, 7'h01};
	localparam logic [31:0] BW_EXP = {3'h0, 13'h0020, 6'b011101, 4'h0, 6'h08};
	localparam rsp_t        ERR    = {1'b1, 1'b1, 32'h0000_0000};
	logic core_clk = 1'b0;
	logic nrst     = 1'b0;
	req_t req      = '0;
	rsp_t rsp;
	rsp_t rsp_b;
	int   n_errors = 0;
	int   checked  = 0;
	int   cycles   = 0;
	always #50 core_clk = ~core_clk;
	// Mixed flags and banked values so a swapped bit or bank shows
	feat_id_regs #(.PART_IDENT(12'h5a5), .HAS_CEIL(1'b0), .IMPL_FEAT_S(32'h8765_4321),
		.MON_COUNT_S(16'h0005)) i_feat_id_regs (
		.CORE_CLK_I(core_clk), .NRST_I(nrst), .REQ_I(req), .RSP_O(rsp));
	// Second copy with no bandwidth or monitor features present
	feat_id_regs #(.MAIN_FEATURES(32'h0000_0000))
		i_feat_id_regs_b (
		.CORE_CLK_I(core_clk), .NRST_I(nrst), .REQ_I(req), .RSP_O(rsp_b));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic rsp_t ok(input logic [31:0] d);
		return {1'b1, 1'b0, d};
	endfunction : ok
	task automatic chk(input string what, input rsp_t exp, input rsp_t got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %b got %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic access(input logic wr, input logic sec, input logic [11:0] a,
		input rsp_t exp, input rsp_t exp_b);
		@(posedge core_clk);
		req <= {1'b1, wr, sec, a, 32'hffff_ffff};
		@(posedge core_clk);
		req.valid <= 1'b0;
		@(negedge core_clk);
		chk("answer", exp, rsp);
		chk("answer absent copy", exp_b, rsp_b);
		@(negedge core_clk);
		chk_bit("answer valid fall", 1'b0, rsp.valid);
	endtask : access
	// Two reads on consecutive edges, each answered one cycle later
	task automatic back_to_back;
		@(posedge core_clk);
		req <= {1'b1, 1'b0, 1'b0, 12'h040, 32'h0000_0000};
		@(posedge core_clk);
		req <= {1'b1, 1'b0, 1'b1, 12'h018, 32'h0000_0000};
		@(negedge core_clk);
		chk("first of pair", ok(BW_EXP), rsp);
		@(posedge core_clk);
		req.valid <= 1'b0;
		@(negedge core_clk);
		chk("second of pair", ok(ID_EXP), rsp);
	endtask : back_to_back
	task automatic close_out;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Run
	// ----------------------------------------
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (9) @(posedge core_clk);
		@(negedge core_clk);
		chk("reset answer", '0, rsp);
		@(posedge core_clk);
		nrst <= 1'b1;
		access(1'b0, 1'b0, 12'h018, ok(ID_EXP), ok(ID_B));
		access(1'b0, 1'b1, 12'h018, ok(ID_EXP), ok(ID_B));
		access(1'b0, 1'b0, 12'h028, ok(32'h0000_0000), ok(32'h0));
		access(1'b0, 1'b1, 12'h028, ok(32'h8765_4321), ok(32'h0));
		access(1'b0, 1'b0, 12'h040, ok(BW_EXP), ERR);
		access(1'b0, 1'b1, 12'h040, ok(BW_EXP), ERR);
		access(1'b0, 1'b0, 12'h090, ok(32'h8000_0004), ERR);
		access(1'b0, 1'b1, 12'h090, ok(32'h8000_0005), ERR);
		access(1'b1, 1'b0, 12'h018, ERR, ERR);
		access(1'b1, 1'b1, 12'h040, ERR, ERR);
		access(1'b0, 1'b0, 12'h018, ok(ID_EXP), ok(ID_B));
		access(1'b0, 1'b0, 12'h01c, ERR, ERR);
		access(1'b0, 1'b1, 12'h019, ERR, ERR);
		back_to_back();
		close_out();
	end
endmodule : tb_feat_id_regs
`default_nettype wire
